// *** prs_pkg.sv ***
package prs_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV0_OFS = 8'h04;
  localparam logic [7:0] DIV1_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  // Control field positions
  localparam int PLL_RESET_BIT = 0;
  localparam int PD_ENABLE_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam int SWITCH_REQ_BIT = 4;
  localparam int SELF_RESET_BIT = 5;
  // Divider field positions, high and low counts are 9 bits (1..511)
  localparam int HIGH_LSB = 0;
  localparam int LOW_LSB = 16;
  localparam int CNT_W = 9;
  // Status field positions
  localparam int BAD_LSB = 0;
  localparam int ACTIVE_BIT = 2;
  localparam int LOCKED_BIT = 3;
  localparam int CASCADE_BIT = 4;
  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [8:0] HIGH_RST = 9'h001;
  localparam logic [8:0] LOW_RST = 9'h001;
  // Timing: reference period and derived counts at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int REF_PERIOD_NS = 40;
  localparam int REF_CYC = REF_PERIOD_NS * CLK_MHZ / 1000;
  localparam int STUCK_REF_CYCLES = 2;
  localparam logic [7:0] STUCK_CYC = 8'(STUCK_REF_CYCLES * REF_CYC);
  localparam logic [1:0] SWITCH_HOLD_EDGES = 2'h3;
  localparam logic [7:0] LOCK_EDGES = 8'h20;
  localparam logic [3:0] SELF_RESET_CYC = 4'h8;
  // Switchover modes
  typedef enum logic [1:0] {
    MODE_AUTO = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_OVERRIDE = 2'h2
  } prs_mode_t;
endpackage

// *** prs_ctrl.sv ***
`timescale 1ns/1ns
// How it works
// - Chained dividers divide by their product
// - Chaining fixed by strap, not by software
// - High and low counts set each duty
// - Gate off blocks phase detector, VCO holds
// - PLL reset clears dividers, outputs, lock
// - After reset release, relock on selected ref
// - Lock means 32 reference edges counted with detector on
// - Auto mode swaps away from stopped reference
// - Manual swap on request held three reference edges
// - Override request beats automatic decision
// - Two bad flags and active indicator out
// - Auto swaps back and forth without limit
// - No swap when both refs stopped
// - Bad flag when input stops toggling
// - Active indicator shows feeding input
// - Stuck two cycles raises flag, selects backup
// - Mux changes on falling edge of target
// - Primary reference selected after reset
// - Only rising request edge causes swap
// - Swap waits for target to be present
module prs_ctrl (
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Static configuration strap, caught after reset release
  input wire logic cascade_strap,
  // Reference clocks, sampled on pclk
  input wire logic primary_ref_clock,
  input wire logic backup_ref_clock,
  // PLL side outputs
  output logic pll_ref_clock,
  output logic phase_detector_active,
  output logic vco_nominal,
  output logic post_divider_0,
  output logic post_divider_1,
  // Status to fabric
  output logic [1:0] bad_clock,
  output logic active_ref,
  output logic pll_locked
);
  typedef enum logic [1:0] {SW_IDLE, SW_GATE, SW_SWAP} prs_sw_t;

  logic [31:0] ctrl;
  logic [8:0] high_cnt [2];
  logic [8:0] low_cnt [2];
  logic cascade;
  logic strap_taken;
  logic [1:0] ref_d;
  logic [1:0] ref_rise;
  logic [1:0] ref_fall;
  logic sel;
  prs_sw_t sw_state;
  logic req_d;
  logic req_armed;
  logic [1:0] req_edges;
  logic [7:0] lock_cnt;
  logic locked_d;
  logic [3:0] self_cnt;
  logic [1:0] div_out;

  // Bus decode and field selection
  wire access = psel & penable & clk_en;
  wire wr = access & pwrite;
  wire hit_ctrl = paddr == prs_pkg::CTRL_OFS;
  wire hit_div0 = paddr == prs_pkg::DIV0_OFS;
  wire hit_div1 = paddr == prs_pkg::DIV1_OFS;
  wire hit_stat = paddr == prs_pkg::STAT_OFS;
  wire mapped = hit_ctrl | hit_div0 | hit_div1 | hit_stat;
  wire pd_enable = ctrl[prs_pkg::PD_ENABLE_BIT];
  wire self_reset_en = ctrl[prs_pkg::SELF_RESET_BIT];
  wire [1:0] mode = ctrl[prs_pkg::MODE_LSB +: 2];
  wire switch_req = ctrl[prs_pkg::SWITCH_REQ_BIT];
  wire pll_reset = ctrl[prs_pkg::PLL_RESET_BIT] | (self_cnt != 4'h0);
  wire cur_bad = sel ? bad_clock[1] : bad_clock[0];
  wire alt_bad = sel ? bad_clock[0] : bad_clock[1];
  wire cur_rise = sel ? ref_rise[1] : ref_rise[0];
  wire cur_fall = sel ? ref_fall[1] : ref_fall[0];
  wire tgt_fall = sel ? ref_fall[0] : ref_fall[1];
  wire cur_level = sel ? ref_d[1] : ref_d[0];

  // Single pclk domain, the handshake waits only while clk_en is low
  assign pready = clk_en;
  assign pslverr = psel & penable & ~mapped;

  // Register writes; the cascade bit has no write path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= prs_pkg::CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl <= pwdata;
    end
  end

  // Read data registered during the setup cycle
  wire [31:0] stat_word = {27'h0, cascade, pll_locked, active_ref, bad_clock};
  wire [31:0] div0_word = {7'h0, low_cnt[0], 7'h0, high_cnt[0]};
  wire [31:0] div1_word = {7'h0, low_cnt[1], 7'h0, high_cnt[1]};
  wire [31:0] rd_mux = hit_ctrl ? ctrl :
                       hit_div0 ? div0_word :
                       hit_div1 ? div1_word :
                       hit_stat ? stat_word : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // Chaining comes only from the strap, caught once after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cascade <= 1'b0;
      strap_taken <= 1'b0;
    end else if (clk_en && !strap_taken) begin
      cascade <= cascade_strap;
      strap_taken <= 1'b1;
    end
  end

  // Sample references, the previous sample yields edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d <= 2'h0;
    end else if (clk_en) begin
      ref_d <= {backup_ref_clock, primary_ref_clock};
    end
  end

  // First divider edge, declared ahead of the loop that reads it
  logic div0_d;
  wire div_rise0 = div_out[0] & ~div0_d;

  // Per-input clock sense and post-scale dividers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      // Per-input state; each divider keeps its own output flop
      logic [7:0] idle_cnt;
      logic [8:0] phase_cnt;
      logic flag;
      logic out_q;
      wire ref_now = gi == 0 ? primary_ref_clock : backup_ref_clock;
      wire tick = gi == 0 ? 1'b1 : (cascade ? div_rise0 : 1'b1);
      // Edges compare the live pin with the last sample
      assign ref_rise[gi] = ref_now & ~ref_d[gi];
      assign ref_fall[gi] = ~ref_now & ref_d[gi];
      assign bad_clock[gi] = flag;
      assign div_out[gi] = out_q;

      // A stopped input raises its flag, any edge clears it
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          idle_cnt <= 8'h00;
          flag <= 1'b0;
        end else if (clk_en) begin
          if (ref_rise[gi] || ref_fall[gi]) begin
            idle_cnt <= 8'h00;
            flag <= 1'b0;
          end else if (idle_cnt >= prs_pkg::STUCK_CYC) begin
            flag <= 1'b1;
          end else begin
            idle_cnt <= idle_cnt + 8'h01;
          end
        end
      end

      // Divider settings written by software
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          high_cnt[gi] <= prs_pkg::HIGH_RST;
          low_cnt[gi] <= prs_pkg::LOW_RST;
        end else if (wr && (gi == 0 ? hit_div0 : hit_div1)) begin
          high_cnt[gi] <= pwdata[prs_pkg::HIGH_LSB +: prs_pkg::CNT_W];
          low_cnt[gi] <= pwdata[prs_pkg::LOW_LSB +: prs_pkg::CNT_W];
        end
      end

      // Output high for high count ticks, then low for low count
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          phase_cnt <= 9'h001;
          out_q <= 1'b0;
        end else if (clk_en) begin
          if (pll_reset) begin
            phase_cnt <= 9'h001;
            out_q <= 1'b0;
          end else if (tick) begin
            if (out_q ? phase_cnt >= high_cnt[gi]
                      : phase_cnt >= low_cnt[gi]) begin
              phase_cnt <= 9'h001;
              out_q <= ~out_q;
            end else begin
              phase_cnt <= phase_cnt + 9'h001;
            end
          end
        end
      end
    end
  endgenerate

  // Rising edge of the first divider steps the second when chained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div0_d <= 1'b0;
    end else if (clk_en) begin
      div0_d <= div_out[0];
    end
  end
  // Divider outputs leave straight from their flops
  assign post_divider_0 = div_out[0];
  assign post_divider_1 = div_out[1];

  // Manual request: rising edge, then three reference edges held high
  wire req_rise = switch_req & ~req_d;
  wire manual_go = req_armed && switch_req &&
                   req_edges == prs_pkg::SWITCH_HOLD_EDGES;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d <= 1'b0;
      req_armed <= 1'b0;
      req_edges <= 2'h0;
    end else if (clk_en) begin
      req_d <= switch_req;
      if (req_rise) begin
        req_armed <= 1'b1;
        req_edges <= 2'h0;
      end else if (!switch_req || manual_go) begin
        req_armed <= 1'b0;
      end else if (req_armed && cur_rise) begin
        req_edges <= req_edges + 2'h1;
      end
    end
  end

  // Choose what starts a swap in each mode
  wire auto_go = cur_bad & ~alt_bad;
  // Mode 3 falls to the default and never starts a swap
  logic start_swap;
  always_comb begin
    unique case (mode)
      prs_pkg::MODE_AUTO: start_swap = auto_go;
      prs_pkg::MODE_MANUAL: start_swap = manual_go;
      // A held request masks the automatic decision
      prs_pkg::MODE_OVERRIDE: start_swap =
        switch_req ? manual_go : auto_go;
      default: start_swap = 1'b0;
    endcase
  end

  // Gate the reference once the state leaves SW_IDLE, wait for the current falling edge,
  // then move the select on the target's falling edge; a high phase under way is cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= SW_IDLE;
      sel <= 1'b0;
    end else if (clk_en) begin
      unique case (sw_state)
        SW_IDLE: begin
          if (start_swap) begin
            sw_state <= SW_GATE;
          end
        end
        SW_GATE: begin
          // A dead current input has no edge left to wait for
          if (cur_fall || cur_bad || !cur_level) begin
            sw_state <= SW_SWAP;
          end
        end
        SW_SWAP: begin
          // A dead target shows no falling edge, so the swap waits
          if (tgt_fall) begin
            sel <= ~sel;
            sw_state <= SW_IDLE;
          end
        end
      endcase
    end
  end

  // Muxed reference, held low while the switch is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ref_clock <= 1'b0;
    end else if (clk_en) begin
      pll_ref_clock <= (sw_state == SW_IDLE) & cur_level;
    end
  end
  assign active_ref = sel;

  // Lock builds from steady reference edges while the detector runs;
  // it may not settle in one go if the reference wanders
  wire lock_ok = !pll_reset && !cur_bad && sw_state == SW_IDLE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= 8'h00;
    end else if (clk_en) begin
      if (!lock_ok) begin
        lock_cnt <= 8'h00;
      end else if (pd_enable && cur_rise &&
                   lock_cnt != prs_pkg::LOCK_EDGES) begin
        lock_cnt <= lock_cnt + 8'h01;
      end
    end
  end
  assign pll_locked = lock_cnt == prs_pkg::LOCK_EDGES;

  // Optional self reset pulse on loss of lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_d <= 1'b0;
      self_cnt <= 4'h0;
    end else if (clk_en) begin
      locked_d <= pll_locked;
      if (self_reset_en && locked_d && !pll_locked) begin
        self_cnt <= prs_pkg::SELF_RESET_CYC;
      end else if (self_cnt != 4'h0) begin
        self_cnt <= self_cnt - 4'h1;
      end
    end
  end

  // Gated detector lets the VCO hold; reset parks it at nominal
  assign phase_detector_active = pd_enable & ~pll_reset;
  assign vco_nominal = pll_reset;
endmodule

// *** prs_ref_src.sv ***
`timescale 1ns/1ns
// Two reference sources at the nominal 40 ns period
module prs_ref_src (
  // Clock and run controls
  input wire logic pclk,
  input wire logic run_primary,
  input wire logic run_backup,
  // Reference outputs
  output logic primary_ref_clock = 1'b0,
  output logic backup_ref_clock = 1'b0
);
  logic [1:0] ph = 2'h0;
  // A stopped source sits low, the failure the sense logic must catch
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    primary_ref_clock <= run_primary & ph[1];
    backup_ref_clock <= run_backup & ~ph[1];
  end
endmodule

// *** prs_ctrl_properties.sv ***
`timescale 1ns/1ns
// Switchover, reset and lock relations seen at the pins
module prs_ctrl_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Reference and PLL side
  input wire logic primary_ref_clock,
  input wire logic pll_ref_clock,
  input wire logic phase_detector_active,
  input wire logic vco_nominal,
  input wire logic post_divider_0,
  input wire logic post_divider_1,
  // Status
  input wire logic [1:0] bad_clock,
  input wire logic active_ref,
  input wire logic pll_locked
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Primary feeds the PLL straight out of reset
  prim_default_a: assert property ($rose(presetn) |-> !active_ref)
    else $error("backup active after reset");
  pll_rst_clear_a: assert property (vco_nominal [*2] |->
    !pll_locked && !post_divider_0 && !post_divider_1)
    else $error("pll reset left state");
  pd_gate_a: assert property (vco_nominal |-> !phase_detector_active)
    else $error("detector open in reset");
  // Eleven cycles without an edge is well past the stuck threshold
  bad_set_a: assert property ($stable(primary_ref_clock) [*8] ##1
    $stable(primary_ref_clock) [*3] |-> bad_clock[0])
    else $error("stuck primary not flagged");
  bad_clear_a: assert property (bad_clock[0] &&
    $changed(primary_ref_clock) |-> ##[1:3] !bad_clock[0])
    else $error("bad flag stuck");
  glitch_free_a: assert property ($changed(active_ref) |->
    !$past(pll_ref_clock))
    else $error("select moved with ref high");
  both_dead_a: assert property ((bad_clock == 2'h3) [*2] |->
    $stable(active_ref))
    else $error("swap with both dead");
  lock_cause_a: assert property ($rose(pll_locked) |->
    phase_detector_active && !vco_nominal)
    else $error("lock without detector");
endmodule

bind prs_ctrl prs_ctrl_chk chk (.pclk(pclk), .presetn(presetn),
  .primary_ref_clock(primary_ref_clock), .pll_ref_clock(pll_ref_clock),
  .phase_detector_active(phase_detector_active), .vco_nominal(vco_nominal),
  .post_divider_0(post_divider_0), .post_divider_1(post_divider_1),
  .bad_clock(bad_clock), .active_ref(active_ref), .pll_locked(pll_locked));

// *** prs_ctrl_bench.sv ***
`timescale 1ns/1ns
module prs_ctrl_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, strap = 1'b0, ce = 1'b1, e, xa;
  logic run0 = 1'b1, run1 = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [1:0] bad;
  logic pready, pslverr, r0, r1, mux, pda, vco, d0, d1, act, lck;
  int error_cnt = 0, num_checks = 0, seed = 32'h798A, h, l, hw, lw;
  int mdl [4]; // Register images
  initial forever #5 pclk = ~pclk;
  prs_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cascade_strap(strap), .primary_ref_clock(r0), .backup_ref_clock(r1),
    .pll_ref_clock(mux), .phase_detector_active(pda), .vco_nominal(vco),
    .post_divider_0(d0), .post_divider_1(d1), .bad_clock(bad),
    .active_ref(act), .pll_locked(lck));
  prs_ref_src src (.pclk(pclk), .run_primary(run0), .run_backup(run1),
    .primary_ref_clock(r0), .backup_ref_clock(r1));
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask
  // Idle cycle at the end keeps back-to-back calls legal
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a < 8'h0C) mdl[a[3:2]] = d;
    chk(e, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask
  function logic pick(input int n);
    case (n)
      0: return bad[0];
      1: return bad[1];
      2: return act;
      3: return lck;
      4: return d0;
      default: return d1;
    endcase
  endfunction
  task wait_on(input int n, input logic v);
    for (int i = 0; i < 500 && pick(n) !== v; i++) @(posedge pclk);
    chk(pick(n), v);
  endtask
  // Times one high and one low phase of a divider output
  task meas(input int n);
    h = 0;
    l = 0;
    while (pick(n) !== 1'b0) @(posedge pclk);
    while (pick(n) !== 1'b1) @(posedge pclk);
    while (pick(n) === 1'b1) begin
      h++;
      @(posedge pclk);
    end
    while (pick(n) === 1'b0) begin
      l++;
      @(posedge pclk);
    end
  endtask
  task reset_dut();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    mdl = '{32'h2, 32'h10001, 32'h10001, 0};
    @(posedge pclk);
  endtask
  task give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog far above the expected run length
  initial begin
    #900000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    reset_dut();
    for (int a = 0; a < 3; a++) rd(8'(a * 4), mdl[a]);
    // A low enable stalls the bus answer for that cycle
    ce <= 1'b0;
    @(posedge pclk);
    chk(pready, 1'b0);
    ce <= 1'b1;
    wait_on(3, 1'b1);
    rd(8'h0C, 32'h0000_0008);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk(e, 1'b1);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0008);
    for (int k = 0; k < 3; k++) begin
      hw = k ? 1 + {$random(seed)} % 256 : 256;
      lw = k ? 1 + {$random(seed)} % 256 : 1;
      wr(8'h04, {7'h00, lw[8:0], 7'h00, hw[8:0]});
      rd(8'h04, mdl[1]);
      meas(4);
      meas(4);
      chk(h, hw);
      chk(l, lw);
    end
    wr(8'h08, 32'h0004_0004);
    meas(5);
    meas(5);
    chk(h, 4);
    chk(l, 4);
    wr(8'h00, 32'h0000_0003);
    repeat (4) @(posedge pclk);
    chk({lck, d0, d1, vco}, 4'h1);
    wr(8'h00, 32'h0000_0002);
    wait_on(3, 1'b1);
    wr(8'h00, 32'h0000_0000);
    chk(pda, 1'b0);
    wr(8'h00, 32'h0000_0022);
    run0 <= 1'b0;
    wait_on(0, 1'b1);
    repeat (3) @(posedge pclk);
    chk(vco, 1'b1);
    wait_on(2, 1'b1);
    run0 <= 1'b1;
    wait_on(0, 1'b0);
    run1 <= 1'b0;
    wait_on(2, 1'b0);
    run1 <= 1'b1;
    wait_on(1, 1'b0);
    // Backup dies first, so no swap may start when the primary follows
    run1 <= 1'b0;
    wait_on(1, 1'b1);
    run0 <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(act, 1'b0);
    // Primary returns first, else the live backup would be chosen
    run0 <= 1'b1;
    wait_on(0, 1'b0);
    run1 <= 1'b1;
    wait_on(1, 1'b0);
    // Manual, override, then the mode that never swaps
    xa = 1'b0;
    for (int k = 1; k < 4; k++) begin
      wr(8'h00, k * 4 + 2);
      wr(8'h00, k * 4 + 18);
      if (k != 3) xa = ~xa;
      repeat (20) @(posedge pclk);
      wait_on(2, xa);
      wr(8'h00, k * 4 + 2);
      repeat (40) @(posedge pclk);
      chk(act, xa);
    end
    strap <= 1'b1;
    reset_dut();
    rd(8'h0C, 32'h0000_0010);
    wr(8'h04, 32'h0003_0002);
    wr(8'h08, 32'h0002_0003);
    meas(5);
    meas(5);
    chk(h, 15);
    chk(l, 10);
    give_verdict();
  end
endmodule
